//--- hw/bt_params.svh
`ifndef BT_PARAMS_SVH
`define BT_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define BT_OFS_CONTROL_ONE 8'h00
`define BT_OFS_CONTROL_TWO 8'h04
`define BT_OFS_IRQ_DMA_ENABLE 8'h0c
`define BT_OFS_STATUS_FLAGS 8'h10
`define BT_OFS_EVENT_GENERATION 8'h14
`define BT_OFS_COUNT_VALUE 8'h24
`define BT_OFS_CLOCK_DIVIDER 8'h28
`define BT_OFS_RELOAD_VALUE 8'h2c

// ****************************************
// Field positions
// ****************************************
`define BT_BIT_RELOAD_BUFFER 7
`define BT_BIT_SINGLE_SHOT 3
`define BT_BIT_SOURCE_SELECT 2
`define BT_BIT_UPDATE_DISABLE 1
`define BT_BIT_COUNT_ENABLE 0
`define BT_MSEL_LSB 4
`define BT_MSEL_MSB 6
`define BT_BIT_DMA_ENABLE 8
`define BT_BIT_IRQ_ENABLE 0
`define BT_BIT_UPDATE_FLAG 0
`define BT_BIT_SW_UPDATE 0

// ****************************************
// Master output codes and reset values
// ****************************************
`define BT_MSEL_SW_UPDATE 3'h0
`define BT_MSEL_ENABLE 3'h1
`define BT_MSEL_UPDATE 3'h2
`define BT_RESET_HALF 16'h0000
`define BT_RESET_MSEL 3'h0

`endif

//--- hw/bt_pkg.sv
package bt_pkg;

    // Control register one fields
    typedef struct packed {
        logic reload_buffer_enable;
        logic single_shot_select;
        logic update_source_select;
        logic update_disable;
        logic count_enable_bit;
    } bt_ctrl_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bt_bus_t;

endpackage

//--- hw/bt_timer.sv
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "bt_params.svh"

module bt_timer (
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic I_DBG_HALT,
    input wire logic I_DEBUG_FREEZE_SELECT,
    input wire logic I_SLAVE_UPDATE,
    output logic O_UPDATE_IRQ,
    output logic O_UPDATE_DMA,
    output logic O_TRIGGER_OUTPUT
);

    // ****************************************
    // Declarations
    // ****************************************
    bt_pkg::bt_bus_t bus;
    bt_pkg::bt_ctrl_t ctrl;
    bt_pkg::bt_ctrl_t next_ctrl;
    logic [2:0] master_output_select;
    logic [2:0] next_master_output_select;
    logic update_dma_enable;
    logic next_update_dma_enable;
    logic update_irq_enable;
    logic next_update_irq_enable;
    logic update_flag;
    logic next_update_flag;
    logic [15:0] divider_value;
    logic [15:0] next_divider_value;
    logic [15:0] reload_value;
    logic [15:0] next_reload_value;
    logic [15:0] reload_shadow;
    logic [15:0] next_reload_shadow;
    logic [15:0] divider_active;
    logic [15:0] next_divider_active;
    logic [15:0] divider_count;
    logic [15:0] next_divider_count;
    logic [15:0] count_value;
    logic [15:0] next_count_value;
    logic internal_count_enable;
    logic next_internal_count_enable;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic dma_pulse;
    logic next_dma_pulse;
    logic trigger;
    logic next_trigger;
    logic [15:0] reload_active;
    logic running;
    logic counter_tick;
    logic overflow;
    logic sw_update_request;
    logic restart;
    logic update_event;
    logic flag_event;
    logic wr_ctrl1;
    logic wr_count;

    // ****************************************
    // Bus decode
    // ****************************************
    // Gather bus signals and decode write targets
    always_comb begin
        bus.addr = I_ADDR;
        bus.wdata = I_WDATA;
        bus.wr = I_WR;
        bus.rd = I_RD;
        wr_ctrl1 = bus.wr && (bus.addr == `BT_OFS_CONTROL_ONE);
        wr_count = bus.wr && (bus.addr == `BT_OFS_COUNT_VALUE);
        sw_update_request = bus.wr && (bus.addr == `BT_OFS_EVENT_GENERATION)
                            && bus.wdata[`BT_BIT_SW_UPDATE];
    end

    // ****************************************
    // Time base
    // ****************************************
    // Tick, overflow and update event conditions
    always_comb begin
        reload_active = ctrl.reload_buffer_enable ? reload_shadow : reload_value;
        running = internal_count_enable
                  && !(I_DBG_HALT && I_DEBUG_FREEZE_SELECT);
        counter_tick = running && (divider_count == divider_active);
        overflow = counter_tick && (reload_active != 16'h0000)
                   && (count_value == reload_active);
        restart = sw_update_request || I_SLAVE_UPDATE;
        update_event = !ctrl.update_disable && (overflow || restart);
        flag_event = update_event
                     && (overflow || !ctrl.update_source_select);
    end

    // Next values of prescaler and counter
    always_comb begin
        // A single shot update also drops the live enable, so the count rests at zero
        next_internal_count_enable = ctrl.count_enable_bit
                                     && !(update_event && ctrl.single_shot_select);
        next_divider_count = divider_count;
        next_count_value = count_value;
        next_divider_active = divider_active;
        next_reload_shadow = reload_shadow;
        if (running) begin
            next_divider_count = counter_tick ? 16'h0000 : divider_count + 16'h0001;
        end
        if (counter_tick && (reload_active != 16'h0000)) begin
            next_count_value = overflow ? 16'h0000 : count_value + 16'h0001;
        end
        if (restart) begin
            next_count_value = 16'h0000;
            next_divider_count = 16'h0000;
        end
        if (wr_count) begin
            next_count_value = bus.wdata[15:0];
        end
        if (update_event) begin
            next_divider_active = divider_value;
            next_reload_shadow = reload_value;
        end
    end

    // Time base registers
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            internal_count_enable <= 1'b0;
            divider_count <= `BT_RESET_HALF;
            count_value <= `BT_RESET_HALF;
            divider_active <= `BT_RESET_HALF;
            reload_shadow <= `BT_RESET_HALF;
        end else begin
            internal_count_enable <= next_internal_count_enable;
            divider_count <= next_divider_count;
            count_value <= next_count_value;
            divider_active <= next_divider_active;
            reload_shadow <= next_reload_shadow;
        end
    end

    // ****************************************
    // Software registers
    // ****************************************
    // Next values of control, enable and flag registers
    always_comb begin
        next_ctrl = ctrl;
        next_master_output_select = master_output_select;
        next_update_dma_enable = update_dma_enable;
        next_update_irq_enable = update_irq_enable;
        next_update_flag = update_flag;
        next_divider_value = divider_value;
        next_reload_value = reload_value;
        if (wr_ctrl1) begin
            next_ctrl.reload_buffer_enable = bus.wdata[`BT_BIT_RELOAD_BUFFER];
            next_ctrl.single_shot_select = bus.wdata[`BT_BIT_SINGLE_SHOT];
            next_ctrl.update_source_select = bus.wdata[`BT_BIT_SOURCE_SELECT];
            next_ctrl.update_disable = bus.wdata[`BT_BIT_UPDATE_DISABLE];
            next_ctrl.count_enable_bit = bus.wdata[`BT_BIT_COUNT_ENABLE];
        end
        if (update_event && ctrl.single_shot_select) begin
            next_ctrl.count_enable_bit = 1'b0;
        end
        if (bus.wr && (bus.addr == `BT_OFS_CONTROL_TWO)) begin
            next_master_output_select = bus.wdata[`BT_MSEL_MSB:`BT_MSEL_LSB];
        end
        if (bus.wr && (bus.addr == `BT_OFS_IRQ_DMA_ENABLE)) begin
            next_update_dma_enable = bus.wdata[`BT_BIT_DMA_ENABLE];
            next_update_irq_enable = bus.wdata[`BT_BIT_IRQ_ENABLE];
        end
        if (bus.wr && (bus.addr == `BT_OFS_STATUS_FLAGS)
            && !bus.wdata[`BT_BIT_UPDATE_FLAG]) begin
            next_update_flag = 1'b0;
        end
        if (flag_event) begin
            next_update_flag = 1'b1;
        end
        if (bus.wr && (bus.addr == `BT_OFS_CLOCK_DIVIDER)) begin
            next_divider_value = bus.wdata[15:0];
        end
        if (bus.wr && (bus.addr == `BT_OFS_RELOAD_VALUE)) begin
            next_reload_value = bus.wdata[15:0];
        end
    end

    // Software register storage
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            ctrl <= '0;
            master_output_select <= `BT_RESET_MSEL;
            update_dma_enable <= 1'b0;
            update_irq_enable <= 1'b0;
            update_flag <= 1'b0;
            divider_value <= `BT_RESET_HALF;
            reload_value <= `BT_RESET_HALF;
        end else begin
            ctrl <= next_ctrl;
            master_output_select <= next_master_output_select;
            update_dma_enable <= next_update_dma_enable;
            update_irq_enable <= next_update_irq_enable;
            update_flag <= next_update_flag;
            divider_value <= next_divider_value;
            reload_value <= next_reload_value;
        end
    end

    // ****************************************
    // Read data and outputs
    // ****************************************
    // Read mux, trigger select and DMA pulse
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (bus.rd) begin
            case (bus.addr)
                `BT_OFS_CONTROL_ONE: begin
                    next_rdata[`BT_BIT_RELOAD_BUFFER] = ctrl.reload_buffer_enable;
                    next_rdata[`BT_BIT_SINGLE_SHOT] = ctrl.single_shot_select;
                    next_rdata[`BT_BIT_SOURCE_SELECT] = ctrl.update_source_select;
                    next_rdata[`BT_BIT_UPDATE_DISABLE] = ctrl.update_disable;
                    next_rdata[`BT_BIT_COUNT_ENABLE] = ctrl.count_enable_bit;
                end
                `BT_OFS_CONTROL_TWO: begin
                    next_rdata[`BT_MSEL_MSB:`BT_MSEL_LSB] = master_output_select;
                end
                `BT_OFS_IRQ_DMA_ENABLE: begin
                    next_rdata[`BT_BIT_DMA_ENABLE] = update_dma_enable;
                    next_rdata[`BT_BIT_IRQ_ENABLE] = update_irq_enable;
                end
                `BT_OFS_STATUS_FLAGS: begin
                    next_rdata[`BT_BIT_UPDATE_FLAG] = update_flag;
                end
                `BT_OFS_COUNT_VALUE: begin
                    next_rdata[15:0] = count_value;
                end
                `BT_OFS_CLOCK_DIVIDER: begin
                    next_rdata[15:0] = divider_value;
                end
                `BT_OFS_RELOAD_VALUE: begin
                    next_rdata[15:0] = reload_value;
                end
                default: begin
                    next_rdata = 32'h0000_0000;
                end
            endcase
        end
        next_dma_pulse = flag_event && update_dma_enable;
        case (master_output_select)
            `BT_MSEL_SW_UPDATE: next_trigger = sw_update_request;
            `BT_MSEL_ENABLE: next_trigger = internal_count_enable;
            `BT_MSEL_UPDATE: next_trigger = update_event;
            default: next_trigger = 1'b0;
        endcase
    end

    // Output registers
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RSTN) begin
            rdata <= 32'h0000_0000;
            dma_pulse <= 1'b0;
            trigger <= 1'b0;
        end else begin
            rdata <= next_rdata;
            dma_pulse <= next_dma_pulse;
            trigger <= next_trigger;
        end
    end

    // Port drive
    assign O_RDATA = rdata;
    assign O_UPDATE_DMA = dma_pulse;
    assign O_TRIGGER_OUTPUT = trigger;
    assign O_UPDATE_IRQ = update_flag && update_irq_enable;

    // ****************************************
    // Assertions
    // ****************************************
    a_enable_delay: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        $rose(ctrl.count_enable_bit) && !(update_event && ctrl.single_shot_select)
        |-> !internal_count_enable ##1 internal_count_enable)
        else $error("count enable not one cycle late");

    a_single_shot_stop: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        update_event && ctrl.single_shot_select |=> !ctrl.count_enable_bit)
        else $error("single shot did not stop");

    a_flag_sets: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        flag_event |=> update_flag)
        else $error("update flag not set");

    a_flag_no_sw: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        !update_flag && sw_update_request && !overflow && !I_SLAVE_UPDATE
        && ctrl.update_source_select |=> !update_flag)
        else $error("flag set despite source select");

    a_restart_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        restart && !wr_count |=> count_value == 16'h0000 && divider_count == 16'h0000)
        else $error("restart did not clear counters");

    a_disable_holds: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        ctrl.update_disable |=> $stable(divider_active) && $stable(reload_shadow))
        else $error("shadow changed with update disabled");

    a_zero_reload: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        reload_active == 16'h0000 && !wr_count && !restart |=> $stable(count_value))
        else $error("counter moved with zero reload");

    a_wrap_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        overflow && !wr_count |=> count_value == 16'h0000)
        else $error("counter did not wrap");

    a_irq_gated: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        flag_event && update_irq_enable && !bus.wr |=> O_UPDATE_IRQ)
        else $error("interrupt missed pending update");

    a_dma_gated: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        O_UPDATE_DMA |-> $past(update_dma_enable) && $past(flag_event))
        else $error("DMA request without cause");

    a_trig_update: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        master_output_select == `BT_MSEL_UPDATE && update_event |=> O_TRIGGER_OUTPUT)
        else $error("trigger missed update");

    a_rsvd_zero: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        1'b1 |=> O_RDATA[31:16] == 16'h0000 && ($past(bus.rd) || O_RDATA == 32'h0000_0000))
        else $error("read data nonzero outside its cycle");

    a_flag_holds: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        update_flag && !(bus.wr && (bus.addr == `BT_OFS_STATUS_FLAGS)) |=> update_flag)
        else $error("update flag lost");

    a_flag_clears: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        bus.wr && (bus.addr == `BT_OFS_STATUS_FLAGS) && !bus.wdata[`BT_BIT_UPDATE_FLAG]
        && !flag_event |=> !update_flag)
        else $error("update flag not cleared");

    a_divider_load: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        update_event |=> divider_active == $past(divider_value))
        else $error("divider not loaded on update");

    a_shadow_load: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        update_event |=> reload_shadow == $past(reload_value))
        else $error("reload shadow not loaded on update");

    a_count_step: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        counter_tick && !overflow && (reload_active != 16'h0000) && !restart && !wr_count
        |=> count_value == $past(count_value) + 16'h0001)
        else $error("counter did not step by one");

    a_freeze_stop: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        I_DBG_HALT && I_DEBUG_FREEZE_SELECT && !restart && !wr_count
        |=> $stable(count_value) && $stable(divider_count))
        else $error("counter moved while frozen");

    a_trig_enable: assert property (@(posedge I_SYS_CLK) disable iff (!I_RSTN)
        master_output_select == `BT_MSEL_ENABLE |=> O_TRIGGER_OUTPUT == $past(internal_count_enable))
        else $error("trigger does not follow count enable");

endmodule

//--- sim/bt_far_end.sv
`timescale 1ns/1ns

// ****************************************
// Far side: trigger consumer and slave controller
// ****************************************
module bt_far_end (
    input wire logic i_clk,
    input wire logic i_trigger,
    output logic o_slave_update
);
    int trig_cnt = 0;

    // Counts every cycle the trigger stands high, as a converter would sample it
    always @(posedge i_clk) begin
        if (i_trigger === 1'b1) begin
            trig_cnt <= trig_cnt + 1;
        end
    end

    initial begin
        o_slave_update = 1'b0;
    end

    // One-cycle update request from the slave controller
    task automatic pulse_slave();
        @(posedge i_clk);
        o_slave_update <= 1'b1;
        @(posedge i_clk);
        o_slave_update <= 1'b0;
    endtask
endmodule

//--- sim/bt_timer_test.sv
`timescale 1ns/1ns
`include "bt_params.svh"

module bt_timer_test;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic halt = 1'b0;
    logic freeze = 1'b0;
    logic slave_upd;
    logic [31:0] rdata;
    logic irq;
    logic dma;
    logic trig;
    logic [31:0] v;
    logic [31:0] a;
    int n_fail = 0;
    int checks = 0;
    int dma_cnt = 0;
    int n;
    int d0;
    int t0;
    logic [7:0] ofs [9] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h24, 8'h28, 8'h2c, 8'h30};

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    bt_timer dut_u (
        .I_SYS_CLK(sys_clk),
        .I_RSTN(rstn),
        .I_ADDR(addr),
        .I_WDATA(wdata),
        .I_WR(wr),
        .I_RD(rd),
        .O_RDATA(rdata),
        .I_DBG_HALT(halt),
        .I_DEBUG_FREEZE_SELECT(freeze),
        .I_SLAVE_UPDATE(slave_upd),
        .O_UPDATE_IRQ(irq),
        .O_UPDATE_DMA(dma),
        .O_TRIGGER_OUTPUT(trig)
    );

    bt_far_end far_u (
        .i_clk(sys_clk),
        .i_trigger(trig),
        .o_slave_update(slave_upd)
    );

    // DMA pulse tally
    always @(posedge sys_clk) begin
        if (dma === 1'b1) begin
            dma_cnt <= dma_cnt + 1;
        end
    end

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic wr_reg(input logic [7:0] ad, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= ad;
        wdata <= {16'h0000, d};
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] ad, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] exp);
        logic [31:0] d;
        rd_reg(ad, d);
        chk(d, exp);
    endtask

    // Cycles until the next trigger pulse, bounded
    task automatic wait_trig(output int cyc);
        cyc = 0;
        do begin
            @(posedge sys_clk);
            #1;
            cyc++;
        end while (trig !== 1'b1 && cyc < 2000);
    endtask

    task automatic summarize();
        if (n_fail == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_fail++;
        summarize();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        foreach (ofs[i]) rd_chk(ofs[i], 32'h0);
        // Reserved bits, flag write semantics, self-clearing request
        wr_reg(`BT_OFS_CONTROL_TWO, 16'hffff);
        rd_chk(`BT_OFS_CONTROL_TWO, 32'h0070);
        wr_reg(`BT_OFS_IRQ_DMA_ENABLE, 16'hffff);
        rd_chk(`BT_OFS_IRQ_DMA_ENABLE, 32'h0101);
        wr_reg(`BT_OFS_IRQ_DMA_ENABLE, 16'h0000);
        wr_reg(`BT_OFS_EVENT_GENERATION, 16'hffff);
        rd_chk(`BT_OFS_EVENT_GENERATION, 32'h0);
        rd_chk(`BT_OFS_STATUS_FLAGS, 32'h1);
        wr_reg(`BT_OFS_STATUS_FLAGS, 16'hffff);
        rd_chk(`BT_OFS_STATUS_FLAGS, 32'h1);
        wr_reg(`BT_OFS_STATUS_FLAGS, 16'h0000);
        rd_chk(`BT_OFS_STATUS_FLAGS, 32'h0);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'hffff);
        rd_chk(`BT_OFS_CONTROL_ONE, 32'h008f);
        repeat (8) @(posedge sys_clk);
        rd_chk(`BT_OFS_COUNT_VALUE, 32'h0);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0000);
        wr_reg(`BT_OFS_COUNT_VALUE, 16'h1234);
        rd_chk(`BT_OFS_COUNT_VALUE, 32'h1234);
        wr_reg(`BT_OFS_CLOCK_DIVIDER, 16'hffff);
        rd_chk(`BT_OFS_CLOCK_DIVIDER, 32'hffff);
        wr_reg(`BT_OFS_CLOCK_DIVIDER, 16'h0000);
        // Enable delay seen on the trigger, then overflow periods
        wr_reg(`BT_OFS_CONTROL_TWO, 16'h0010);
        wr_reg(`BT_OFS_RELOAD_VALUE, 16'h0005);
        wr_reg(`BT_OFS_COUNT_VALUE, 16'h0000);
        wr_reg(`BT_OFS_IRQ_DMA_ENABLE, 16'h0001);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0001);
        chk(trig, 1'b0);
        @(posedge sys_clk);
        #1;
        chk(trig, 1'b0);
        @(posedge sys_clk);
        #1;
        chk(trig, 1'b1);
        wr_reg(`BT_OFS_CONTROL_TWO, 16'h0020);
        wait_trig(n);
        wait_trig(n);
        chk(n, 6);
        chk(irq, 1'b1);
        wr_reg(`BT_OFS_CLOCK_DIVIDER, 16'h0002);
        wait_trig(n);
        wait_trig(n);
        chk(n, 18);
        wr_reg(`BT_OFS_IRQ_DMA_ENABLE, 16'h0000);
        chk(irq, 1'b0);
        wr_reg(`BT_OFS_CLOCK_DIVIDER, 16'h0000);
        wait_trig(n);
        // Debug halt with and without freeze
        wr_reg(`BT_OFS_RELOAD_VALUE, 16'h00ff);
        @(posedge sys_clk);
        halt <= 1'b1;
        freeze <= 1'b1;
        rd_reg(`BT_OFS_COUNT_VALUE, a);
        repeat (10) @(posedge sys_clk);
        rd_chk(`BT_OFS_COUNT_VALUE, a);
        @(posedge sys_clk);
        freeze <= 1'b0;
        repeat (4) @(posedge sys_clk);
        rd_reg(`BT_OFS_COUNT_VALUE, v);
        chk(v != a, 1'b1);
        @(posedge sys_clk);
        halt <= 1'b0;
        // Single shot stops at the update
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0000);
        wr_reg(`BT_OFS_COUNT_VALUE, 16'h0000);
        wr_reg(`BT_OFS_RELOAD_VALUE, 16'h0003);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0009);
        wait_trig(n);
        repeat (5) @(posedge sys_clk);
        rd_chk(`BT_OFS_CONTROL_ONE, 32'h0008);
        rd_chk(`BT_OFS_COUNT_VALUE, 32'h0);
        // Software update: restart, flag, DMA, source select, disable
        wr_reg(`BT_OFS_STATUS_FLAGS, 16'h0000);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0000);
        wr_reg(`BT_OFS_CONTROL_TWO, 16'h0000);
        wr_reg(`BT_OFS_IRQ_DMA_ENABLE, 16'h0100);
        d0 = dma_cnt;
        t0 = far_u.trig_cnt;
        wr_reg(`BT_OFS_COUNT_VALUE, 16'h0007);
        wr_reg(`BT_OFS_EVENT_GENERATION, 16'h0001);
        repeat (3) @(posedge sys_clk);
        rd_chk(`BT_OFS_COUNT_VALUE, 32'h0);
        chk(dma_cnt - d0, 1);
        chk(far_u.trig_cnt - t0, 1);
        rd_chk(`BT_OFS_STATUS_FLAGS, 32'h1);
        wr_reg(`BT_OFS_STATUS_FLAGS, 16'h0000);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0004);
        wr_reg(`BT_OFS_EVENT_GENERATION, 16'h0001);
        repeat (3) @(posedge sys_clk);
        chk(dma_cnt - d0, 1);
        rd_chk(`BT_OFS_STATUS_FLAGS, 32'h0);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0002);
        wr_reg(`BT_OFS_COUNT_VALUE, 16'h0007);
        wr_reg(`BT_OFS_EVENT_GENERATION, 16'h0001);
        repeat (3) @(posedge sys_clk);
        rd_chk(`BT_OFS_COUNT_VALUE, 32'h0);
        rd_chk(`BT_OFS_STATUS_FLAGS, 32'h0);
        chk(dma_cnt - d0, 1);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0000);
        far_u.pulse_slave();
        repeat (3) @(posedge sys_clk);
        chk(dma_cnt - d0, 2);
        rd_chk(`BT_OFS_STATUS_FLAGS, 32'h1);
        wr_reg(`BT_OFS_STATUS_FLAGS, 16'h0000);
        wr_reg(`BT_OFS_IRQ_DMA_ENABLE, 16'h0000);
        wr_reg(`BT_OFS_EVENT_GENERATION, 16'h0001);
        repeat (3) @(posedge sys_clk);
        chk(dma_cnt - d0, 2);
        // Buffered reload waits for the update
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0080);
        wr_reg(`BT_OFS_RELOAD_VALUE, 16'h0005);
        wr_reg(`BT_OFS_EVENT_GENERATION, 16'h0001);
        wr_reg(`BT_OFS_RELOAD_VALUE, 16'h0002);
        wr_reg(`BT_OFS_COUNT_VALUE, 16'h0004);
        wr_reg(`BT_OFS_CONTROL_TWO, 16'h0020);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0081);
        wait_trig(n);
        chk(n < 10, 1'b1);
        wait_trig(n);
        chk(n, 3);
        wr_reg(`BT_OFS_CONTROL_ONE, 16'h0000);
        summarize();
    end
endmodule
